// ### hdl/gpc_map.svh
`ifndef GPC_MAP_SVH
`define GPC_MAP_SVH
// Overview of operation
// [R1] Non-alternate pins reset to floating input
// [R2] Debug pins reset with their documented pulls; pads pull only in input mode, so alternate debug pins get none
// [R3] Input modes: trigger on, buffer off, pulls
// [R4] Input sample register captures pins every cycle
// [R5] Analog: no buffer, no pulls, reads zero
// [R6] Output mode: trigger on, buffer on, no pulls
// [R7] Push-pull drives latch; latch reads back
// [R8] Open-drain drives low only; pin read back
// [R9] Alternate: peripheral drives buffer, pin sampled
// [R10] Alternate readback: pin for OD, latch PP
// [R11] Outputs have speed grade and drive type
// [R12] Software uses input mode for interrupt pins
// [R13] Set/clear write changes selected latch bits
// [R14] Locked pin configuration frozen until reset
// [R15] Slow crystal pins owned while oscillator on
// [R16] Fast crystal pins owned while oscillator on
// [R17] Pull-up settles high, pull-down settles low
// [R18] Mode field: input, output, alternate, analog
// [R19] Pull field: none, pull-up, pull-down
// [R20] Low half sets, high clears, set wins
// [R21] Set/clear register reads as zero
// [R22] Alternate mode takes value, enable from peripheral
// [R23] Pin samples pass a two-flop synchronizer

// Register byte offsets
`define GPC_OFS_MODE   8'h00
`define GPC_OFS_OMODE  8'h04
`define GPC_OFS_SPEED  8'h08
`define GPC_OFS_PULL   8'h0C
`define GPC_OFS_IDATA  8'h10
`define GPC_OFS_ODATA  8'h14
`define GPC_OFS_SETCLR 8'h18
`define GPC_OFS_LOCK   8'h1C
`define GPC_OFS_AFL    8'h20
`define GPC_OFS_AFH    8'h24
// Lock register key bit
`define GPC_LOCK_KEY   16
// Port reset values (debug pins on ports A and B)
`define GPC_MODE_RST_A  32'hA800_0000
`define GPC_MODE_RST_B  32'h0000_0280
`define GPC_SPEED_RST_A 32'h0C00_0000
`define GPC_SPEED_RST_B 32'h0000_00C0
`define GPC_PULL_RST_A  32'h6400_0000
`define GPC_PULL_RST_B  32'h0000_0100
`define GPC_ZERO32      32'h0000_0000
// Crystal pins (port C 14/15, port H 0/1)
`define GPC_LSE_PINS_C  16'hC000
`define GPC_HSE_PINS_H  16'h0003
`define GPC_ZERO16      16'h0000
`endif

// ### hdl/gpc_pkg.sv
package gpc_pkg;
    // Per-pin mode field encoding
    typedef enum logic [1:0] {
        GPC_MODE_IN  = 2'h0,
        GPC_MODE_OUT = 2'h1,
        GPC_MODE_AF  = 2'h2,
        GPC_MODE_AN  = 2'h3
    } gpc_mode_t;
    // Per-pin pull field encoding
    typedef enum logic [1:0] {
        GPC_PULL_NONE = 2'h0,
        GPC_PULL_UP   = 2'h1,
        GPC_PULL_DOWN = 2'h2,
        GPC_PULL_RSVD = 2'h3
    } gpc_pull_t;
    // Lock sequence, Gray coded
    typedef enum logic [1:0] {
        GPC_LK_IDLE  = 2'h0,
        GPC_LK_ONE   = 2'h1,
        GPC_LK_ZERO  = 2'h3,
        GPC_LK_ARMED = 2'h2
    } gpc_lock_t;
    // Whole port state
    typedef struct packed {
        logic [31:0] mode;
        logic [15:0] omode;
        logic [31:0] speed;
        logic [31:0] pull;
        logic [15:0] odata;
        logic [15:0] idata;
        logic [63:0] af;
        logic [15:0] lock;
        logic        lock_key;
        logic [15:0] lk_mask;
        gpc_lock_t   lk_st;
        logic [31:0] prdata;
        logic        pslverr;
    } gpc_state_t;
endpackage : gpc_pkg

// ### hdl/gpc_sync.sv
module gpc_sync #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Asynchronous in, synchronous out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    // Two stages; only the second reads the first
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] held;
    } gpc_sync_st_t;

    gpc_sync_st_t st_reg;   // Current stages
    gpc_sync_st_t st_next;  // Next stages

    // Shift the pins through both stages
    always_comb begin
        st_next      = st_reg;
        st_next.meta = d;
        st_next.held = st_reg.meta;
    end

    // Stage registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.held;
endmodule : gpc_sync

// ### hdl/gpc_port.sv
// The APB slave port and the register offsets are this design's own decisions.
`include "gpc_map.svh"

module gpc_port #(
    parameter logic [31:0] MODE_RST  = `GPC_ZERO32,
    parameter logic [31:0] SPEED_RST = `GPC_ZERO32,
    parameter logic [31:0] PULL_RST  = `GPC_ZERO32,
    parameter logic [15:0] LSE_PINS  = `GPC_ZERO16,
    parameter logic [15:0] HSE_PINS  = `GPC_ZERO16
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pad side
    input  wire logic [15:0] pad_in,
    output logic      [15:0] pad_out,
    output logic      [15:0] pad_oe_n,
    output logic      [15:0] pull_up_en,
    output logic      [15:0] pull_down_en,
    output logic      [15:0] schmitt_en,
    output logic      [31:0] speed_sel,
    // Peripheral side
    input  wire logic [15:0] af_out,
    input  wire logic [15:0] af_oe,
    output logic      [63:0] af_sel,
    output logic      [15:0] af_in,
    // Clock controller
    input  wire logic        low_speed_osc_enable,
    input  wire logic        high_speed_osc_enable
);
    // Widen a pin mask to two bits per pin
    function automatic logic [31:0] gpc_x2(input logic [15:0] m);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            r[2*i +: 2] = {2{m[i]}};
        end
        return r;
    endfunction : gpc_x2

    // Widen a pin mask to four bits per pin
    function automatic logic [63:0] gpc_x4(input logic [15:0] m);
        logic [63:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            r[4*i +: 4] = {4{m[i]}};
        end
        return r;
    endfunction : gpc_x4

    // Keep locked bits, take the rest from the write
    function automatic logic [63:0] gpc_merge(input logic [63:0] o,
                                               input logic [63:0] n,
                                               input logic [63:0] k);
        return (o & k) | (n & ~k);
    endfunction : gpc_merge

    // Reset image of the whole port
    localparam gpc_pkg::gpc_state_t ST_RST = '{
        mode: MODE_RST, omode: '0, speed: SPEED_RST, pull: PULL_RST,
        odata: '0, idata: '0, af: '0, lock: '0, lock_key: 1'b0,
        lk_mask: '0, lk_st: gpc_pkg::GPC_LK_IDLE, prdata: '0,
        pslverr: 1'b0};

    gpc_pkg::gpc_state_t st_reg;   // Registered port state
    gpc_pkg::gpc_state_t st_next;  // Its next value
    logic [15:0] sync_q;           // Pins after synchronizer
    logic [15:0] osc_own;          // Pins taken by an oscillator
    logic [15:0] an_mask;          // Pins in analog mode
    logic [15:0] out_mask;         // Pins in general output mode
    logic        acc_setup;        // APB setup phase
    logic        acc_wr;           // APB write access phase
    logic        acc_rd;           // APB read access phase
    logic [31:0] rd_word;          // Read mux result
    logic        rd_hit;           // Address decodes
    logic [31:0] lk2;              // Lock mask, two bits per pin
    logic [63:0] lk4;              // Lock mask, four bits per pin

    // [R23] two-flop pin synchronizer
    gpc_sync #(
        .W (16)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (pad_in),
        .q       (sync_q)
    );

    // [R15] [R16] crystal pins yield to oscillators
    assign osc_own = ({16{low_speed_osc_enable}} & LSE_PINS)
                   | ({16{high_speed_osc_enable}} & HSE_PINS);

    // Per-pin pad control from the current configuration
    for (genvar gi = 0; gi < 16; gi++) begin : g_pin
        wire logic [1:0] md   = st_reg.mode[2*gi +: 2];
        wire logic [1:0] pl   = st_reg.pull[2*gi +: 2];
        wire logic       is_o = (md == gpc_pkg::GPC_MODE_OUT);
        wire logic       is_a = (md == gpc_pkg::GPC_MODE_AF);
        // [R22] peripheral owns value and enable
        wire logic       val  = is_a ? af_out[gi] : st_reg.odata[gi];
        wire logic       en   = is_a ? af_oe[gi] : is_o;
        wire logic       od   = st_reg.omode[gi];
        assign an_mask[gi]  = (md == gpc_pkg::GPC_MODE_AN);
        // An oscillator-owned pin is not a port output, even in output mode
        assign out_mask[gi] = is_o & ~osc_own[gi];
        // [R7] [R8] push-pull or low-side only
        assign pad_oe_n[gi] = ~(~osc_own[gi] & en & (~od | ~val));
        assign pad_out[gi]  = val & ~od;
        // [R3] [R17] [R19] pulls only in digital input
        assign pull_up_en[gi] = ~osc_own[gi]
                              & (md == gpc_pkg::GPC_MODE_IN)
                              & (pl == gpc_pkg::GPC_PULL_UP);
        assign pull_down_en[gi] = ~osc_own[gi]
                                & (md == gpc_pkg::GPC_MODE_IN)
                                & (pl == gpc_pkg::GPC_PULL_DOWN);
        // [R5] [R6] [R9] trigger off in analog and on oscillator-owned pins
        assign schmitt_en[gi] = ~osc_own[gi] & ~an_mask[gi];
    end

    assign lk2 = gpc_x2(st_reg.lock);
    assign lk4 = gpc_x4(st_reg.lock);

    // APB phase decode
    assign acc_setup = psel & ~penable;
    assign acc_wr    = psel & penable & pwrite;
    assign acc_rd    = psel & penable & ~pwrite;

    // Read mux; unmapped offsets read zero and flag an error
    always_comb begin
        rd_word = `GPC_ZERO32;
        rd_hit  = 1'b1;
        case (paddr)
            `GPC_OFS_MODE:   rd_word = st_reg.mode;
            `GPC_OFS_OMODE:  rd_word = {`GPC_ZERO16, st_reg.omode};
            `GPC_OFS_SPEED:  rd_word = st_reg.speed;
            `GPC_OFS_PULL:   rd_word = st_reg.pull;
            // [R4] [R8] [R10] pin state readback
            `GPC_OFS_IDATA:  rd_word = {`GPC_ZERO16, st_reg.idata};
            // [R7] [R10] last written latch
            `GPC_OFS_ODATA:  rd_word = {`GPC_ZERO16, st_reg.odata};
            // [R21] write-only, reads zero
            `GPC_OFS_SETCLR: rd_word = `GPC_ZERO32;
            `GPC_OFS_LOCK: begin
                rd_word = {`GPC_ZERO16, st_reg.lock};
                rd_word[`GPC_LOCK_KEY] = st_reg.lock_key;
            end
            `GPC_OFS_AFL:    rd_word = st_reg.af[31:0];
            `GPC_OFS_AFH:    rd_word = st_reg.af[63:32];
            default:         rd_hit  = 1'b0;
        endcase
    end

    // Next state: sampling, bus writes, lock sequence
    always_comb begin
        st_next = st_reg;
        // [R4] [R5] [R9] sample every cycle, analog zero
        st_next.idata = sync_q & schmitt_en;
        // Read data is taken in setup, so access needs no wait
        if (acc_setup) begin
            st_next.prdata  = pwrite ? `GPC_ZERO32 : rd_word;
            st_next.pslverr = ~rd_hit;
        end
        if (acc_wr) begin
            case (paddr)
                // [R14] [R18] locked fields keep their value
                `GPC_OFS_MODE: st_next.mode =
                    32'(gpc_merge({`GPC_ZERO32, st_reg.mode},
                                  {`GPC_ZERO32, pwdata}, {`GPC_ZERO32, lk2}));
                // [R11] drive type per output pin
                `GPC_OFS_OMODE: st_next.omode =
                    (st_reg.omode & st_reg.lock) | (pwdata[15:0] & ~st_reg.lock);
                // [R11] speed grade per output pin
                `GPC_OFS_SPEED: st_next.speed =
                    32'(gpc_merge({`GPC_ZERO32, st_reg.speed},
                                  {`GPC_ZERO32, pwdata}, {`GPC_ZERO32, lk2}));
                `GPC_OFS_PULL: st_next.pull =
                    32'(gpc_merge({`GPC_ZERO32, st_reg.pull},
                                  {`GPC_ZERO32, pwdata}, {`GPC_ZERO32, lk2}));
                `GPC_OFS_ODATA: st_next.odata = pwdata[15:0];
                // [R13] [R20] set wins over clear
                `GPC_OFS_SETCLR: st_next.odata =
                    (st_reg.odata & ~pwdata[31:16]) | pwdata[15:0];
                `GPC_OFS_AFL: st_next.af[31:0] =
                    32'(gpc_merge({`GPC_ZERO32, st_reg.af[31:0]},
                                  {`GPC_ZERO32, pwdata},
                                  {`GPC_ZERO32, lk4[31:0]}));
                `GPC_OFS_AFH: st_next.af[63:32] =
                    32'(gpc_merge({`GPC_ZERO32, st_reg.af[63:32]},
                                  {`GPC_ZERO32, pwdata},
                                  {`GPC_ZERO32, lk4[63:32]}));
                default: st_next.af = st_reg.af;
            endcase
        end
        // [R14] lock key: write 1, 0, 1 with one mask, then read
        if (!st_reg.lock_key && psel && penable
            && paddr == `GPC_OFS_LOCK) begin
            case (st_reg.lk_st)
                gpc_pkg::GPC_LK_IDLE: begin
                    if (pwrite && pwdata[`GPC_LOCK_KEY]) begin
                        st_next.lk_st   = gpc_pkg::GPC_LK_ONE;
                        st_next.lk_mask = pwdata[15:0];
                    end
                end
                gpc_pkg::GPC_LK_ONE: begin
                    st_next.lk_st = (pwrite && !pwdata[`GPC_LOCK_KEY]
                                     && pwdata[15:0] == st_reg.lk_mask)
                                    ? gpc_pkg::GPC_LK_ZERO : gpc_pkg::GPC_LK_IDLE;
                end
                gpc_pkg::GPC_LK_ZERO: begin
                    st_next.lk_st = (pwrite && pwdata[`GPC_LOCK_KEY]
                                     && pwdata[15:0] == st_reg.lk_mask)
                                    ? gpc_pkg::GPC_LK_ARMED : gpc_pkg::GPC_LK_IDLE;
                end
                gpc_pkg::GPC_LK_ARMED: begin
                    st_next.lk_st = gpc_pkg::GPC_LK_IDLE;
                    // A read completes the sequence; a write aborts it
                    if (!pwrite) begin
                        st_next.lock     = st_reg.lock | st_reg.lk_mask;
                        st_next.lock_key = 1'b1;
                    end
                end
                default: st_next.lk_st = gpc_pkg::GPC_LK_IDLE;
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        // [R1] [R2] reset configuration from parameters
        if (!presetn) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // Bus and peripheral outputs
    assign pready    = 1'b1;
    assign prdata    = st_reg.prdata;
    assign pslverr   = st_reg.pslverr;
    assign speed_sel = st_reg.speed;
    assign af_sel    = st_reg.af;
    assign af_in     = st_reg.idata;

    // Checks on the port behaviour
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_sample;
        ##3 1 |-> st_reg.idata == ($past(pad_in, 3) & $past(schmitt_en));
    endproperty
    a_sample: assert property (p_sample) // [R4]
        else $error("input sample does not follow synchronized pin");

    property p_analog_zero;
        ##1 1 |-> (st_reg.idata & $past(an_mask)) == `GPC_ZERO16;
    endproperty
    a_analog_zero: assert property (p_analog_zero) // [R5]
        else $error("analog pin reads nonzero");

    property p_setclr;
        acc_wr && paddr == `GPC_OFS_SETCLR |=>
            st_reg.odata == (($past(st_reg.odata) & ~$past(pwdata[31:16]))
                             | $past(pwdata[15:0]));
    endproperty
    a_setclr: assert property (p_setclr) // [R20]
        else $error("set/clear result wrong");

    property p_setclr_read;
        acc_setup && !pwrite && paddr == `GPC_OFS_SETCLR
            |=> prdata == `GPC_ZERO32 && !pslverr;
    endproperty
    a_setclr_read: assert property (p_setclr_read) // [R21]
        else $error("set/clear register read nonzero");

    property p_lock_mode;
        ##1 1 |-> ((st_reg.mode ^ $past(st_reg.mode))
                   & gpc_x2($past(st_reg.lock))) == `GPC_ZERO32;
    endproperty
    a_lock_mode: assert property (p_lock_mode) // [R14]
        else $error("locked mode field changed");

    property p_pull_no_drive;
        ((pull_up_en | pull_down_en) & ~pad_oe_n) == `GPC_ZERO16;
    endproperty
    a_pull_no_drive: assert property (p_pull_no_drive) // [R3]
        else $error("pulled pin is also driven");

    property p_out_no_pull;
        (out_mask & (pull_up_en | pull_down_en | ~schmitt_en)) == `GPC_ZERO16;
    endproperty
    a_out_no_pull: assert property (p_out_no_pull) // [R6]
        else $error("output pin has pull or trigger off");

    property p_od_low_only;
        (st_reg.omode & pad_out) == `GPC_ZERO16;
    endproperty
    a_od_low_only: assert property (p_od_low_only) // [R8]
        else $error("open-drain pin driven high");

    property p_osc_own;
        low_speed_osc_enable |-> (pad_oe_n & LSE_PINS) == LSE_PINS
                                 && (schmitt_en & LSE_PINS) == `GPC_ZERO16;
    endproperty
    a_osc_own: assert property (p_osc_own) // [R15]
        else $error("slow crystal pin used by port");

    c_lock_done: cover property ($rose(st_reg.lock_key));
    c_setclr:    cover property (acc_wr && paddr == `GPC_OFS_SETCLR);
    c_analog:    cover property (an_mask != `GPC_ZERO16);
    c_unmapped:  cover property (acc_setup && !rd_hit);
endmodule : gpc_port

// ### tb/gpc_pad_model.sv
module gpc_pad_model (
    // Clock for the pattern on undriven pins
    input  wire logic        pclk,
    // Pad controls from the port
    input  wire logic [15:0] pad_out,
    input  wire logic [15:0] pad_oe_n,
    input  wire logic [15:0] pull_up_en,
    input  wire logic [15:0] pull_down_en,
    // Outside drivers on the board
    input  wire logic [15:0] ext_en,
    input  wire logic [15:0] ext_val,
    // Resolved wire levels
    output logic      [15:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] float_q = 16'h5A5A; // Undriven pin level, changes every cycle

    // A floating pin must never look stable, or a stale level could pass
    always @(posedge pclk) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
            else if (ext_en[i]) pad_in[i] = ext_val[i];
            else if (pull_up_en[i]) pad_in[i] = 1'b1;
            else if (pull_down_en[i]) pad_in[i] = 1'b0;
            else pad_in[i] = float_q[i];
        end
    end
endmodule : gpc_pad_model

// ### tb/testbench.sv
`include "gpc_map.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // Bus side
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, speed_sel;
    logic        pready, pslverr;
    // Pins, peripherals and oscillator enables
    logic [15:0] pad_in, pad_out, pad_oe_n, pull_up_en, pull_down_en, schmitt_en, af_in;
    logic [15:0] af_out = 16'h0, af_oe = 16'h0, ext_en = 16'h0, ext_val = 16'h0;
    logic [63:0] af_sel;
    logic        lse = 1'b0, hse = 1'b0;
    // Reference model state
    logic [31:0] m_mode, m_speed, m_pull;
    logic [63:0] m_af;
    logic [15:0] m_om, m_od, m_lk;
    logic        m_key;
    // Predicted pad behaviour
    logic [15:0] e_dr, e_vl, e_up, e_dn, e_st;
    int          err_count = 0, checked = 0, cyc = 0;
    logic [31:0] rv;
    logic [7:0]  ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};

    gpc_port #(
        .MODE_RST  (`GPC_MODE_RST_A),
        .SPEED_RST (`GPC_SPEED_RST_A),
        .PULL_RST  (`GPC_PULL_RST_A),
        .LSE_PINS  (`GPC_LSE_PINS_C),
        .HSE_PINS  (`GPC_HSE_PINS_H)
    ) dut_u (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .pad_in, .pad_out, .pad_oe_n, .pull_up_en, .pull_down_en, .schmitt_en,
        .speed_sel, .af_out, .af_oe, .af_sel, .af_in,
        .low_speed_osc_enable (lse),
        .high_speed_osc_enable (hse)
    );

    gpc_pad_model pad_u (
        .pclk, .pad_out, .pad_oe_n, .pull_up_en, .pull_down_en, .ext_en, .ext_val, .pad_in
    );

    // 250 MHz bus clock
    always #2 pclk = ~pclk;

    // Hang guard, far above the expected fourteen hundred or so cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", n, e, s);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic x);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        x = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
        logic [31:0] r;
        logic        x;
        apb(1'b0, a, 32'h0, r, x);
        chk("prdata", r, e);
        chk("pslverr", x, ee);
    endtask : rd

    // Write, then mirror it in the model; locked fields keep old bits
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r, l2;
        logic [63:0] l4;
        logic        x;
        apb(1'b1, a, d, r, x);
        for (int i = 0; i < 16; i++) begin
            l2[2*i+:2] = {2{m_lk[i]}};
            l4[4*i+:4] = {4{m_lk[i]}};
        end
        case (a)
            8'h00: m_mode = (d & ~l2) | (m_mode & l2);
            8'h04: m_om = (d[15:0] & ~m_lk) | (m_om & m_lk);
            8'h08: m_speed = (d & ~l2) | (m_speed & l2);
            8'h0C: m_pull = (d & ~l2) | (m_pull & l2);
            8'h14: m_od = d[15:0];
            8'h18: m_od = (m_od & ~d[31:16]) | d[15:0];
            8'h20: m_af[31:0] = (d & ~l4[31:0]) | (m_af[31:0] & l4[31:0]);
            8'h24: m_af[63:32] = (d & ~l4[63:32]) | (m_af[63:32] & l4[63:32]);
            default: ;
        endcase
    endtask : wr

    task automatic reset_model();
        m_mode = `GPC_MODE_RST_A;
        m_speed = `GPC_SPEED_RST_A;
        m_pull = `GPC_PULL_RST_A;
        m_af = 64'h0;
        m_om = 16'h0;
        m_od = 16'h0;
        m_lk = 16'h0;
        m_key = 1'b0;
    endtask : reset_model

    // Read back every mapped register except input data against the model
    task automatic regs();
        logic [31:0] e;
        foreach (ra[i]) begin
            case (ra[i])
                8'h00: e = m_mode;
                8'h04: e = {16'h0, m_om};
                8'h08: e = m_speed;
                8'h0C: e = m_pull;
                8'h14: e = {16'h0, m_od};
                8'h1C: e = {15'h0, m_key, m_lk};
                8'h20: e = m_af[31:0];
                8'h24: e = m_af[63:32];
                default: e = 32'h0;
            endcase
            rd(ra[i], e, 1'b0);
        end
        chk("speed_sel", speed_sel, m_speed);
        chk("af_sel", af_sel, m_af);
    endtask : regs

    // Expected pad controls per pin from mode, drive type, pull and ownership
    task automatic predict();
        logic [15:0] own;
        int          m, p;
        logic        src, en;
        own = (lse ? `GPC_LSE_PINS_C : 16'h0) | (hse ? `GPC_HSE_PINS_H : 16'h0);
        for (int i = 0; i < 16; i++) begin
            m = int'(m_mode[2*i+:2]);
            p = int'(m_pull[2*i+:2]);
            src = (m == 2) ? af_out[i] : m_od[i];
            en = !own[i] && ((m == 2) ? af_oe[i] : (m == 1));
            e_dr[i] = en && (!m_om[i] || !src);
            e_vl[i] = e_dr[i] && src;
            e_st[i] = !own[i] && m != 3;
            e_up[i] = !own[i] && m == 0 && p == 1;
            e_dn[i] = !own[i] && m == 0 && p == 2;
        end
    endtask : predict

    task automatic pins(input logic [15:0] k);
        chk("drive", ~pad_oe_n & k, e_dr & k);
        chk("level", pad_out & ~pad_oe_n & k, e_vl & k);
        chk("pull_up", pull_up_en & k, e_up & k);
        chk("pull_down", pull_down_en & k, e_dn & k);
        chk("trigger", schmitt_en & k, e_st & k);
    endtask : pins

    // Outside drive on released pins, then the sampled levels
    task automatic sample();
        logic [15:0] kn, lv;
        logic [31:0] r;
        logic        x;
        ext_en <= ~e_dr & 16'($urandom);
        ext_val <= 16'($urandom);
        repeat (6) @(posedge pclk);
        kn = e_dr | ext_en | e_up | e_dn | ~e_st;
        lv = ((e_dr & e_vl) | (~e_dr & ext_en & ext_val) | (~e_dr & ~ext_en & e_up)) & e_st;
        apb(1'b0, `GPC_OFS_IDATA, 32'h0, r, x);
        chk("idata", r & {16'h0, kn}, {16'h0, lv & kn});
        chk("af_in", af_in & kn, lv & kn);
    endtask : sample

    task automatic lock_seq(input logic [15:0] k);
        wr(`GPC_OFS_LOCK, {15'h0, 1'b1, k});
        wr(`GPC_OFS_LOCK, {15'h0, 1'b0, k});
        wr(`GPC_OFS_LOCK, {15'h0, 1'b1, k});
        // Read data is taken in setup, before the closing read locks
        rd(`GPC_OFS_LOCK, {15'h0, m_key, m_lk}, 1'b0);
        m_lk = k;
        m_key = 1'b1;
        rd(`GPC_OFS_LOCK, {15'h0, 1'b1, k}, 1'b0);
    endtask : lock_seq

    // Main sequence
    initial begin
        rv = $urandom(32'h1FE6);
        reset_model();
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        regs();
        predict();
        pins(~16'hE000);
        rd(8'h28, 32'h0, 1'b1);
        wr(8'h3C, 32'hFFFF_FFFF);
        $display("test reset values done");
        for (int it = 0; it < 20; it++) begin
            lse <= 1'($urandom);
            hse <= 1'($urandom);
            af_out <= 16'($urandom);
            af_oe <= 16'($urandom);
            if (it == 10) lock_seq(16'($urandom));
            foreach (ra[i]) begin
                if (ra[i] != 8'h1C) wr(ra[i], $urandom);
            end
            wr(`GPC_OFS_IDATA, $urandom);
            predict();
            pins(16'hFFFF);
            sample();
            regs();
        end
        $display("test random configurations done");
        presetn <= 1'b0;
        lse <= 1'b0;
        hse <= 1'b0;
        repeat (2) @(posedge pclk);
        reset_model();
        presetn <= 1'b1;
        @(posedge pclk);
        regs();
        predict();
        pins(16'hFFFF);
        // wake pins sampled in input mode
        sample();
        $display("test second reset done");
        summarize();
    end
endmodule : testbench
